// >>> svs_pkg.sv
// Shared constants and types for the sensor video sync timing block
// How it works
// RL1: Level mode: line sync active for trail minus lead plus eight-times-extend plus pixel count.
// RL2: Level mode: line sync inactive for the rest of the row period.
// RL3: Level mode: first pixel appears lead plus one row clock after line sync rises.
// RL4: Level mode: frame sync inactive for inter-frame rows, overhead, integration, lead minus trail.
// RL5: Level mode: frame sync active for trail minus lead plus row period times rows.
// RL6: Pulse mode: line sync high three row clocks, low row period minus three.
// RL7: Pulse mode: frame sync high three row clocks, low frame period minus three.
// RL8: Pulse mode: first pixel 145 minus one row clock after line sync rises.
// RL9: Slave mode: controller holds each row trigger at least two master clocks.
// RL10: Slave mode: first pixel a fixed latency after the row trigger falls.
// RL11: Slave mode: row triggers spaced at least latency plus column count apart.
// RL12: Slave mode: frame trigger falls 1 to 96 master clocks after last row trigger; the block has no check or error flag for this.
// RL13: Slave mode: controller holds each frame trigger at least three master clocks.
package svs_pkg;
    localparam logic [7:0] SVS_OFS_CTRL = 8'h00;
    localparam logic [7:0] SVS_OFS_LINE = 8'h04;
    localparam logic [7:0] SVS_OFS_FRAME = 8'h08;
    localparam logic [7:0] SVS_OFS_ROW = 8'h0C;
    localparam logic [7:0] SVS_OFS_GEOM = 8'h10;
    localparam logic [7:0] SVS_OFS_OVH = 8'h14;
    localparam logic [7:0] SVS_OFS_SLAVE = 8'h18;
    localparam logic [7:0] SVS_OFS_FPER = 8'h1C;
    localparam logic [7:0] SVS_OFS_STATUS = 8'h20;
    localparam int SVS_CTRL_EN_BIT = 0;
    localparam int SVS_CTRL_MODE_LSB = 1;
    localparam int SVS_CTRL_BLANK_BIT = 3;
    localparam int SVS_ERR_LSB = 16;
    localparam logic [15:0] SVS_RST_ROW_PER = 16'h0320;
    localparam logic [15:0] SVS_RST_NPIX = 16'h0288;
    localparam logic [15:0] SVS_RST_NROWS = 16'h01E8;
    localparam logic [31:0] SVS_RST_FRAME_PER = 32'h0006_1A80;
    localparam logic [15:0] SVS_RST_LAT = 16'h0010;
    localparam logic [15:0] SVS_RST_NCOL = 16'h0288;
    localparam logic [31:0] SVS_PULSE_WIDTH = 32'h0000_0003;
    localparam logic [31:0] SVS_PULSE_PIX_OFS = 32'd145;
    localparam logic [31:0] SVS_BLANK_MULT = 32'h0000_0008;
    localparam logic [15:0] SVS_ROW_TRIG_MIN = 16'h0002;
    localparam logic [15:0] SVS_FRAME_TRIG_MIN = 16'h0003;
    localparam int SVS_PIX_W = 10;
    localparam int SVS_FIFO_D = 4;
    typedef enum logic [1:0] {
        SVS_MODE_LEVEL = 2'b00,
        SVS_MODE_PULSE = 2'b01,
        SVS_MODE_SLAVE = 2'b10
    } svs_mode_t;
    typedef enum logic [1:0] {
        SVS_ST_IDLE = 2'b00,
        SVS_ST_WAIT = 2'b01,
        SVS_ST_PIX = 2'b11
    } svs_state_t;
endpackage

// >>> svs_sync.sv
// Two flip-flop synchroniser for signals from outside the pclk domain
`timescale 1ns/10ps
module svs_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// >>> svs_fifo.sv
// Small pixel FIFO with valid/ready on both sides
`timescale 1ns/10ps
module svs_fifo #(
    parameter int W = 10,
    parameter int D = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;
    assign out_valid = (count != '0);
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(D-1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == AW'(D-1)) ? '0 : rptr + 1'b1;
            end
            count <= next_count;
            // Ready comes from a flop so the source port sees a clean level
            in_ready <= (next_count != (AW+1)'(D));
        end
    end
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end
endmodule

// >>> svs_top.sv
// Video sync generator and pixel output port with APB register access
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module svs_top
    import svs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mclk,
    input wire logic row_trigger,
    input wire logic frame_trigger,
    input wire logic [SVS_PIX_W-1:0] src_data,
    input wire logic src_valid,
    output logic src_ready,
    output logic pix_clk,
    output logic line_sync,
    output logic frame_sync,
    output logic pix_valid,
    output logic [SVS_PIX_W-1:0] pix_data
);
    typedef struct packed {
        logic enable;
        svs_mode_t mode;
        logic blank_pixel_extend;
        logic [15:0] line_sync_lead;
        logic [15:0] line_sync_trail;
        logic [15:0] frame_sync_lead;
        logic [15:0] frame_sync_trail;
        logic [15:0] row_period_cycles;
        logic [15:0] active_pixel_count;
        logic [15:0] active_row_count;
        logic [15:0] inter_frame_rows;
        logic [15:0] row_overhead_cycles;
        logic [15:0] row_integration_cycles;
        logic [15:0] trigger_to_pixel_latency;
        logic [15:0] column_count;
        logic [31:0] frame_period_cycles;
        logic [3:0] err;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic mclk_q;
        logic row_q;
        logic frame_q;
        logic [31:0] hcnt;
        logic [31:0] fcnt;
        logic [15:0] pcnt;
        logic [15:0] row_w;
        logic [15:0] frame_w;
        logic [31:0] row_gap;
        svs_state_t st;
        logic pix_clk;
        logic line_sync;
        logic frame_sync;
        logic pix_valid;
        logic [SVS_PIX_W-1:0] pix_data;
        logic [15:0] frames;
    } svs_regs_t;

    svs_regs_t r;
    svs_regs_t next_r;
    logic [2:0] sync_in;
    logic mclk_s;
    logic row_s;
    logic frame_s;
    logic [SVS_PIX_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;

    svs_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({mclk, row_trigger, frame_trigger}),
        .sync_out(sync_in)
    );
    assign mclk_s = sync_in[2];
    assign row_s = sync_in[1];
    assign frame_s = sync_in[0];

    svs_fifo #(.W(SVS_PIX_W), .D(SVS_FIFO_D)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_data(src_data),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Derived timing, all in row-unit clocks
    logic tick;
    logic [31:0] ls_act;
    logic [31:0] fs_act;
    logic [31:0] fs_inact;
    logic [31:0] row_per;
    logic [31:0] frame_len;
    logic [31:0] pix_start;
    logic [31:0] npix;
    logic slot;
    logic apb_acc;
    logic apb_wr;
    logic row_fall;
    logic frame_fall;
    logic [3:0] err_set;

    assign fifo_pop = tick && slot && fifo_valid;

    always_comb begin
        next_r = r;
        err_set = '0;
        slot = 1'b0;
        tick = mclk_s && !r.mclk_q;
        row_fall = tick && r.row_q && !row_s;
        frame_fall = tick && r.frame_q && !frame_s;
        row_per = {16'h0000, r.row_period_cycles};
        npix = {16'h0000, r.active_pixel_count};
        ls_act = {16'h0000, r.line_sync_trail} - {16'h0000, r.line_sync_lead}
            + (r.blank_pixel_extend ? SVS_BLANK_MULT : 32'h0000_0000) + npix; // RL1
        fs_act = {16'h0000, r.frame_sync_trail} - {16'h0000, r.frame_sync_lead}
            + 32'(row_per * {16'h0000, r.active_row_count}); // RL5
        fs_inact = 32'(row_per * {16'h0000, r.inter_frame_rows}) + {16'h0000, r.row_overhead_cycles}
            + {16'h0000, r.row_integration_cycles} + {16'h0000, r.frame_sync_lead}
            - {16'h0000, r.frame_sync_trail}; // RL4
        if (r.mode == SVS_MODE_PULSE) begin
            frame_len = r.frame_period_cycles; // RL7
            pix_start = SVS_PULSE_PIX_OFS - 32'h0000_0001; // RL8
        end else begin
            frame_len = fs_act + fs_inact;
            pix_start = {16'h0000, r.line_sync_lead} + 32'h0000_0001; // RL3
        end
        next_r.mclk_q = mclk_s;
        next_r.pix_clk = mclk_s;

        // APB slave: one wait state, answer registered
        apb_acc = psel && penable && !r.pready;
        apb_wr = psel && penable && r.pready && pwrite;
        next_r.pready = apb_acc;
        next_r.pslverr = 1'b0;
        if (apb_acc) begin
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                SVS_OFS_CTRL: next_r.prdata = {28'h0000000, r.blank_pixel_extend, r.mode, r.enable};
                SVS_OFS_LINE: next_r.prdata = {r.line_sync_trail, r.line_sync_lead};
                SVS_OFS_FRAME: next_r.prdata = {r.frame_sync_trail, r.frame_sync_lead};
                SVS_OFS_ROW: next_r.prdata = {r.active_pixel_count, r.row_period_cycles};
                SVS_OFS_GEOM: next_r.prdata = {r.inter_frame_rows, r.active_row_count};
                SVS_OFS_OVH: next_r.prdata = {r.row_integration_cycles, r.row_overhead_cycles};
                SVS_OFS_SLAVE: next_r.prdata = {r.column_count, r.trigger_to_pixel_latency};
                SVS_OFS_FPER: next_r.prdata = r.frame_period_cycles;
                SVS_OFS_STATUS: next_r.prdata = {12'h000, r.err, r.frames};
                default: next_r.pslverr = 1'b1;
            endcase
        end
        if (apb_wr && !r.pslverr) begin
            case (paddr)
                SVS_OFS_CTRL: begin
                    next_r.enable = pwdata[SVS_CTRL_EN_BIT];
                    next_r.mode = svs_mode_t'(pwdata[SVS_CTRL_MODE_LSB +: 2]);
                    next_r.blank_pixel_extend = pwdata[SVS_CTRL_BLANK_BIT];
                end
                SVS_OFS_LINE: {next_r.line_sync_trail, next_r.line_sync_lead} = pwdata;
                SVS_OFS_FRAME: {next_r.frame_sync_trail, next_r.frame_sync_lead} = pwdata;
                SVS_OFS_ROW: {next_r.active_pixel_count, next_r.row_period_cycles} = pwdata;
                SVS_OFS_GEOM: {next_r.inter_frame_rows, next_r.active_row_count} = pwdata;
                SVS_OFS_OVH: {next_r.row_integration_cycles, next_r.row_overhead_cycles} = pwdata;
                SVS_OFS_SLAVE: {next_r.column_count, next_r.trigger_to_pixel_latency} = pwdata;
                SVS_OFS_FPER: next_r.frame_period_cycles = pwdata;
                default: ;
            endcase
        end

        // Timing engine, advances only on a row-unit clock edge
        if (!r.enable) begin
            // Park one step before zero so the first tick opens a full row and frame
            next_r.hcnt = 32'hFFFF_FFFF;
            next_r.fcnt = 32'hFFFF_FFFF;
            // First row trigger after enable is never flagged as too close
            next_r.row_gap = 32'hFFFF_FFFF;
            next_r.pcnt = 16'h0000;
            next_r.st = SVS_ST_IDLE;
            next_r.line_sync = 1'b0;
            next_r.frame_sync = 1'b0;
            next_r.pix_valid = 1'b0;
            next_r.row_q = row_s;
            next_r.frame_q = frame_s;
        end else if (tick) begin
            next_r.row_q = row_s;
            next_r.frame_q = frame_s;
            if (r.mode == SVS_MODE_SLAVE) begin
                // Sync outputs follow the external triggers
                next_r.line_sync = row_s;
                next_r.frame_sync = frame_s;
                next_r.row_w = row_s ? r.row_w + 16'h0001 : 16'h0000;
                next_r.frame_w = frame_s ? r.frame_w + 16'h0001 : 16'h0000;
                next_r.row_gap = (&r.row_gap) ? r.row_gap : r.row_gap + 32'h0000_0001;
                if (row_fall && r.row_w < SVS_ROW_TRIG_MIN) begin // RL9
                    err_set[0] = 1'b1;
                end
                if (frame_fall && r.frame_w < SVS_FRAME_TRIG_MIN) begin // RL13
                    err_set[1] = 1'b1;
                end
                if (row_s && !r.row_q) begin
                    next_r.row_gap = 32'h0000_0000;
                    if (r.row_gap < {16'h0000, r.trigger_to_pixel_latency} + {16'h0000, r.column_count}) begin // RL11
                        err_set[2] = 1'b1;
                    end
                end
                if (frame_fall) begin
                    next_r.frames = r.frames + 16'h0001;
                end
                case (r.st)
                    SVS_ST_IDLE: begin
                        next_r.pcnt = 16'h0000;
                    end
                    SVS_ST_WAIT: begin
                        next_r.pcnt = r.pcnt + 16'h0001;
                        if (r.pcnt + 16'h0001 >= r.trigger_to_pixel_latency) begin // RL10
                            next_r.st = SVS_ST_PIX;
                            next_r.pcnt = 16'h0000;
                            slot = 1'b1;
                        end
                    end
                    SVS_ST_PIX: begin
                        next_r.pcnt = r.pcnt + 16'h0001;
                        if (r.pcnt + 16'h0001 >= r.column_count) begin
                            next_r.st = SVS_ST_IDLE;
                        end else begin
                            slot = 1'b1;
                        end
                    end
                    default: next_r.st = SVS_ST_IDLE;
                endcase
                if (row_fall) begin
                    next_r.st = SVS_ST_WAIT;
                    next_r.pcnt = 16'h0000;
                end
            end else begin
                next_r.st = SVS_ST_IDLE;
                next_r.hcnt = (r.hcnt + 32'h0000_0001 >= row_per) ? 32'h0000_0000 : r.hcnt + 32'h0000_0001;
                next_r.fcnt = r.fcnt + 32'h0000_0001;
                if (r.fcnt + 32'h0000_0001 >= frame_len) begin
                    next_r.fcnt = 32'h0000_0000;
                    next_r.hcnt = 32'h0000_0000;
                    next_r.frames = r.frames + 16'h0001;
                end
                if (r.mode == SVS_MODE_PULSE) begin
                    next_r.line_sync = next_r.hcnt < SVS_PULSE_WIDTH; // RL6
                    next_r.frame_sync = next_r.fcnt < SVS_PULSE_WIDTH; // RL7
                    slot = next_r.hcnt >= pix_start && next_r.hcnt < pix_start + npix; // RL8
                end else begin
                    next_r.line_sync = next_r.hcnt < ls_act; // RL1 RL2
                    next_r.frame_sync = next_r.fcnt < fs_act; // RL4 RL5
                    slot = next_r.frame_sync && next_r.hcnt >= pix_start
                        && next_r.hcnt < pix_start + npix; // RL3
                end
            end
            // One pixel per row-unit clock; empty FIFO sends zero and flags it
            next_r.pix_valid = slot;
            next_r.pix_data = fifo_valid ? fifo_data : '0;
            if (slot && !fifo_valid) begin
                err_set[3] = 1'b1;
            end
        end
        // Error flags: write one to clear, a new event wins over the clear
        if (apb_wr && paddr == SVS_OFS_STATUS) begin
            next_r.err = r.err & ~pwdata[SVS_ERR_LSB +: 4];
        end
        next_r.err = next_r.err | err_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.mode <= SVS_MODE_LEVEL;
            r.row_period_cycles <= SVS_RST_ROW_PER;
            r.active_pixel_count <= SVS_RST_NPIX;
            r.active_row_count <= SVS_RST_NROWS;
            r.frame_period_cycles <= SVS_RST_FRAME_PER;
            r.trigger_to_pixel_latency <= SVS_RST_LAT;
            r.column_count <= SVS_RST_NCOL;
            r.st <= SVS_ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign pix_clk = r.pix_clk;
    assign line_sync = r.line_sync;
    assign frame_sync = r.frame_sync;
    assign pix_valid = r.pix_valid;
    assign pix_data = r.pix_data;
endmodule

// >>> svs_monitor.sv
// Concurrent checks on the sync and pixel timing of the video port
`timescale 1ns/10ps
module svs_monitor
    import svs_pkg::*;
#(
    parameter int TK = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic row_trigger,
    input wire logic line_sync,
    input wire logic frame_sync,
    input wire logic pix_valid
);
    logic [31:0] rg [9];
    int hi [2];
    int lo [2];
    logic [1:0] arm;
    int age;
    int rta;
    logic rt_q;
    wire logic [1:0] sy = {frame_sync, line_sync};
    wire logic en = rg[0][0];
    wire logic pm = en && rg[0][2:1] == SVS_MODE_PULSE;
    wire logic lm = en && rg[0][2:1] == SVS_MODE_LEVEL;
    wire logic sm = en && rg[0][2:1] == SVS_MODE_SLAVE;
    // Shadow of written registers, plus high/low run lengths of both syncs in pclk cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rg <= '{default: '0};
            hi <= '{0, 0};
            lo <= '{0, 0};
            arm <= 2'h0;
            age <= 0;
            rta <= 0;
            rt_q <= 1'h0;
        end else begin
            if (psel && penable && pready && pwrite && !pslverr && paddr < 8'h24) begin
                rg[paddr[5:2]] <= pwdata;
            end
            for (int i = 0; i < 2; i++) begin
                hi[i] <= sy[i] ? hi[i] + 1 : 0;
                lo[i] <= sy[i] ? 0 : lo[i] + 1;
                arm[i] <= en && (arm[i] || (hi[i] != 0 && !sy[i]));
            end
            age <= (line_sync && hi[0] == 0) ? 1 : age + 1;
            rta <= (!row_trigger && rt_q) ? 1 : rta + 1;
            rt_q <= row_trigger;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_pulse_line_high: assert property (pm && $fell(line_sync) |-> hi[0] == SVS_PULSE_WIDTH * TK)
        else $error("line pulse width wrong");
    chk_pulse_line_gap: assert property (pm && arm[0] && $rose(line_sync) |-> lo[0] == (rg[3][15:0] - 3) * TK)
        else $error("line pulse gap wrong");
    chk_pulse_frame_high: assert property (pm && $fell(frame_sync) |-> hi[1] == SVS_PULSE_WIDTH * TK)
        else $error("frame pulse width wrong");
    chk_pulse_frame_gap: assert property (pm && arm[1] && $rose(frame_sync) |-> lo[1] == (rg[7] - 3) * TK)
        else $error("frame pulse gap wrong");
    chk_pulse_pix_ofs: assert property (pm && $rose(pix_valid) |-> age == (SVS_PULSE_PIX_OFS - 1) * TK)
        else $error("pulse pixel offset wrong");
    chk_level_line_high: assert property (lm && $fell(line_sync) |->
        hi[0] == (rg[1][31:16] - rg[1][15:0] + SVS_BLANK_MULT * rg[0][3] + rg[3][31:16]) * TK)
        else $error("level line width wrong");
    chk_level_line_gap: assert property (lm && arm[0] && $rose(line_sync) |->
        lo[0] == (rg[3][15:0] - rg[3][31:16] + rg[1][15:0] - rg[1][31:16] - SVS_BLANK_MULT * rg[0][3]) * TK)
        else $error("level line gap wrong");
    chk_level_pix_ofs: assert property (lm && $rose(pix_valid) |-> age == (rg[1][15:0] + 1) * TK)
        else $error("level pixel offset wrong");
    chk_level_frame_gap: assert property (lm && arm[1] && $rose(frame_sync) |->
        lo[1] == (rg[4][31:16] * rg[3][15:0] + rg[5][15:0] + rg[5][31:16] + rg[2][15:0] - rg[2][31:16]) * TK)
        else $error("level frame gap wrong");
    chk_level_frame_high: assert property (lm && $fell(frame_sync) |->
        hi[1] == (rg[2][31:16] - rg[2][15:0] + rg[3][15:0] * rg[4][15:0]) * TK)
        else $error("level frame width wrong");
    chk_slave_pix_lat: assert property (sm && $rose(pix_valid) |->
        rta >= rg[6][15:0] * TK + 4 && rta <= rg[6][15:0] * TK + 11)
        else $error("slave pixel latency wrong");
endmodule
bind svs_top svs_monitor #(.TK(8)) chk_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .row_trigger(row_trigger), .line_sync(line_sync), .frame_sync(frame_sync), .pix_valid(pix_valid));

// >>> svs_far_end.sv
// Far-end model: camera controller triggers and pixel receiver
`timescale 1ns/10ps
module svs_far_end
    import svs_pkg::*;
(
    input wire logic mclk,
    input wire logic pix_valid,
    input wire logic [SVS_PIX_W-1:0] pix_data,
    output logic row_trigger,
    output logic frame_trigger
);
    logic [SVS_PIX_W-1:0] got [$];
    initial begin
        row_trigger = 1'h0;
        frame_trigger = 1'h0;
    end
    // Sampled at the next row clock, just before the port moves on
    always @(posedge mclk) begin
        if (pix_valid === 1'h1) begin
            got.push_back(pix_data);
        end
    end
    // Triggers move on the falling row clock, clear of the sampling edge
    task automatic trig(input logic fr, input int hi, input int gap);
        @(negedge mclk);
        if (fr) begin
            frame_trigger = 1'h1;
        end else begin
            row_trigger = 1'h1;
        end
        repeat (hi) @(negedge mclk);
        row_trigger = 1'h0;
        frame_trigger = 1'h0;
        repeat (gap) @(negedge mclk);
    endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the sync timing block
`timescale 1ns/10ps
module testbench
    import svs_pkg::*;
;
    logic pclk = 1'h0;
    logic mclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, src_valid = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [SVS_PIX_W-1:0] src_data = 10'h000;
    logic [31:0] prdata, q;
    logic pready, pslverr, src_ready, pix_clk, line_sync, frame_sync, pix_valid, row_trigger, frame_trigger, e;
    logic [SVS_PIX_W-1:0] pix_data;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    initial forever #10 pclk = ~pclk;
    initial begin
        #7;
        forever #80 mclk = ~mclk;
    end
    svs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclk(mclk),
        .row_trigger(row_trigger), .frame_trigger(frame_trigger), .src_data(src_data), .src_valid(src_valid),
        .src_ready(src_ready), .pix_clk(pix_clk), .line_sync(line_sync), .frame_sync(frame_sync),
        .pix_valid(pix_valid), .pix_data(pix_data));
    svs_far_end far (.mclk(mclk), .pix_valid(pix_valid), .pix_data(pix_data), .row_trigger(row_trigger),
        .frame_trigger(frame_trigger));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %0t %s", $time, msg);
            failures++;
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic t_regs();
        apb(1'h0, SVS_OFS_ROW, 32'h0);
        chk(q, {SVS_RST_NPIX, SVS_RST_ROW_PER}, "row reset");
        apb(1'h0, SVS_OFS_FPER, 32'h0);
        chk(q, SVS_RST_FRAME_PER, "frame period reset");
        apb(1'h1, SVS_OFS_LINE, 32'h0004_0002);
        apb(1'h0, SVS_OFS_LINE, 32'h0);
        chk(q, 32'h0004_0002, "line readback");
        apb(1'h1, 8'h24, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1, "unmapped write");
        apb(1'h0, 8'h24, 32'h0);
        chk({e, q[30:0]}, 32'h8000_0000, "unmapped read");
        @(posedge mclk);
        repeat (2) @(posedge pclk);
        chk({31'h0, pix_clk}, 32'h0, "pixel clock still low");
        repeat (2) @(posedge pclk);
        chk({31'h0, pix_clk}, 32'h1, "pixel clock follows row clock");
        $display("register test done");
    endtask
    task automatic t_fifo();
        int n;
        n = 0;
        for (int k = 0; k < 6; k++) begin
            src_data <= 10'(n + 1);
            src_valid <= 1'h1;
            @(posedge pclk);
            if (src_ready === 1'h1) n++;
        end
        src_valid <= 1'h0;
        chk(32'(n), 32'(SVS_FIFO_D), "fifo depth");
        $display("fifo fill test done");
    endtask
    task automatic t_pulse();
        apb(1'h1, SVS_OFS_ROW, 32'h0006_00A0);
        apb(1'h1, SVS_OFS_FPER, 32'h0000_0140);
        apb(1'h1, SVS_OFS_CTRL, 32'h0000_0003);
        @(posedge line_sync);
        far.got.delete();
        @(posedge line_sync);
        chk(32'(far.got.size()), 32'h6, "pulse pixels per row");
        for (int i = 0; i < 6; i++) chk(32'(far.got[i]), 32'(i < 4 ? i + 1 : 0), "pixel order");
        @(posedge frame_sync);
        apb(1'h1, SVS_OFS_CTRL, 32'h0);
        apb(1'h0, SVS_OFS_STATUS, 32'h0);
        chk(32'(q[19]), 32'h1, "underrun flag");
        apb(1'h1, SVS_OFS_STATUS, 32'h0008_0000);
        apb(1'h0, SVS_OFS_STATUS, 32'h0);
        chk(32'(q[19]), 32'h0, "underrun clear");
        $display("pulse mode test done");
    endtask
    task automatic t_level();
        apb(1'h1, SVS_OFS_FRAME, 32'h0);
        apb(1'h1, SVS_OFS_ROW, 32'h0008_0028);
        apb(1'h1, SVS_OFS_GEOM, 32'h0001_0002);
        apb(1'h1, SVS_OFS_OVH, 32'h0);
        apb(1'h1, SVS_OFS_CTRL, 32'h0000_0009);
        @(posedge frame_sync);
        far.got.delete();
        @(posedge frame_sync);
        chk(32'(far.got.size()), 32'h10, "level pixels per frame");
        apb(1'h1, SVS_OFS_CTRL, 32'h0);
        $display("level mode test done");
    endtask
    task automatic t_slave();
        apb(1'h1, SVS_OFS_SLAVE, 32'h0004_0003);
        apb(1'h1, SVS_OFS_CTRL, 32'h0000_0005);
        far.got.delete();
        repeat (3) far.trig(1'h0, 2, 5);
        far.trig(1'h1, 3, 4);
        chk(32'(far.got.size()), 32'hC, "slave pixel count");
        apb(1'h0, SVS_OFS_STATUS, 32'h0);
        chk(32'(q[18:16]), 32'h0, "no trigger flags");
        far.trig(1'h0, 1, 1);
        far.trig(1'h0, 2, 9);
        far.trig(1'h1, 2, 9);
        apb(1'h0, SVS_OFS_STATUS, 32'h0);
        chk(32'(q[18:16]), 32'h7, "short trigger flags");
        apb(1'h1, SVS_OFS_STATUS, 32'h0007_0000);
        apb(1'h0, SVS_OFS_STATUS, 32'h0);
        chk(32'(q[18:16]), 32'h0, "trigger flags clear");
        apb(1'h1, SVS_OFS_CTRL, 32'h0);
        $display("slave mode test done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            $display("BAD %0t timeout", $time);
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_fifo();
        t_pulse();
        t_level();
        t_slave();
        give_verdict();
    end
endmodule
